// file: design/protection_monitor.sv
// protection alarms, user events, remote pins and ahb-lite register slave of a dc load
// Function
// - device alarm switches DC input off, shows alarm pop-up, sounds if enabled.
// - voltage above overvoltage threshold raises its alarm and cuts DC input.
// - current above overcurrent threshold raises its alarm and cuts DC input.
// - power above overpower threshold raises its alarm and cuts DC input.
// - protection thresholds range zero to 1.1 nominal, default 110 percent.
// - overvoltage alarm drives analog alarm pin; alarms readable over the bus.
// - alarms stay pending until acknowledged, fresh or already shown as status.
// - acknowledged alarm clears when condition gone; otherwise needs another acknowledge.
// - undervoltage and undercurrent events fire below threshold, range zero to nominal.
// - overvoltage, overcurrent, overpower events fire above threshold, zero to nominal.
// - each event has action none, signal, warning or alarm; reset gives none.
// - signal gives status message; warning adds a warning pop-up.
// - enabled events are evaluated whether the DC input is on or off.
// - one sound setting governs device alarms and user events alike.
// - profile load replaces event thresholds and actions; default profile clears them.
// - in remote control, input-off request low turns DC off, released turns on.
// - analog current and power set values accepted only while remote-enable low.
module protection_monitor
    import monitor_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire monitor_pkg::meas_s meas,
    input wire logic meas_valid,
    input wire logic profile_load,
    input wire monitor_pkg::event_cfg_s profile_cfg,
    input wire logic remote_enable_n,
    input wire logic input_off_request_n,
    output logic dc_input_on,
    output logic overvoltage_alarm_pin,
    output logic set_value_accept,
    output monitor_pkg::indication_s indication,
    output logic irq
);
    import monitor_pkg::*;

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [15:0] clip(input logic [15:0] value, input logic [15:0] limit);
        clip = (value > limit) ? limit : value;
    endfunction : clip

    function automatic logic [15:0] prot_limit(input logic [15:0] nominal);
        logic [31:0] scaled;
        scaled = (32'(nominal) * 32'(PROT_NUM)) / 32'(PROT_DEN);
        prot_limit = (scaled > 32'h0000ffff) ? 16'hffff : scaled[15:0];
    endfunction : prot_limit

    localparam logic [NUM_PROT-1:0][15:0] NOMINAL = {POWER_NOMINAL, CURR_NOMINAL, VOLT_NOMINAL};
    localparam logic [NUM_EVENTS-1:0][15:0] EV_NOMINAL =
        {POWER_NOMINAL, CURR_NOMINAL, CURR_NOMINAL, VOLT_NOMINAL, VOLT_NOMINAL};

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [1:0] remote_sync;
    logic [1:0] off_sync;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            remote_sync <= 2'h3;
            off_sync <= 2'h3;
        end
        else if (ce)
        begin
            remote_sync <= {remote_sync[0], remote_enable_n};
            off_sync <= {off_sync[0], input_off_request_n};
        end
    end

    logic remote_active;
    logic remote_off;
    assign remote_active = !remote_sync[1];
    assign remote_off = remote_active && !off_sync[1];

    // ************************************************************
    // ahb-lite slave
    // ************************************************************
    logic wr_pend;
    logic [7:0] wr_addr;
    logic addr_ok;
    logic [7:0] a_ofs;
    assign addr_ok = hsel && hready && htrans[1];
    assign a_ofs = haddr[7:0];

    logic [1:0] ctrl;
    logic [NUM_PROT-1:0][15:0] prot_thr;
    event_cfg_s ev_cfg;
    logic [NUM_PROT-1:0] prot_pending;
    logic [NUM_PROT-1:0] prot_cond;
    logic [NUM_EVENTS-1:0] ev_cond;
    logic [NUM_EVENTS-1:0] ev_fired;
    logic [NUM_EVENTS-1:0] ev_alarm;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_enable;

    logic wr_ack;
    logic wr_irq_clear;
    logic wr_profile_default;
    assign wr_ack = wr_pend && (wr_addr == OFS_ACK);
    assign wr_irq_clear = wr_pend && (wr_addr == OFS_IRQ_CLEAR);
    assign wr_profile_default = wr_pend && (wr_addr == OFS_PROFILE)
        && hwdata[PROFILE_DEFAULT_BIT];

    logic [31:0] next_rdata;
    always_comb
    begin
        next_rdata = 32'h0;
        case (a_ofs)
            OFS_CTRL: next_rdata = {30'h0, ctrl};
            OFS_ALARM: next_rdata = {26'h0, prot_cond, prot_pending};
            OFS_PROT_THR: next_rdata = {16'h0, prot_thr[0]};
            OFS_PROT_THR + 8'h04: next_rdata = {16'h0, prot_thr[1]};
            OFS_PROT_THR + 8'h08: next_rdata = {16'h0, prot_thr[2]};
            OFS_EVT_THR: next_rdata = {16'h0, ev_cfg.threshold[0]};
            OFS_EVT_THR + 8'h04: next_rdata = {16'h0, ev_cfg.threshold[1]};
            OFS_EVT_THR + 8'h08: next_rdata = {16'h0, ev_cfg.threshold[2]};
            OFS_EVT_THR + 8'h0c: next_rdata = {16'h0, ev_cfg.threshold[3]};
            OFS_EVT_THR + 8'h10: next_rdata = {16'h0, ev_cfg.threshold[4]};
            OFS_EVT_ACTION: next_rdata = {22'h0, ev_cfg.action};
            OFS_EVT_STATUS: next_rdata = {22'h0, ev_alarm, ev_fired};
            OFS_IRQ_STATUS: next_rdata = {24'h0, irq_status};
            OFS_IRQ_ENABLE: next_rdata = {24'h0, irq_enable};
            OFS_STATE: next_rdata = {28'h0, set_value_accept, remote_off, remote_active,
                dc_input_on};
            default: next_rdata = 32'h0;
        endcase
    end

    // zero wait states: read data is captured at the address phase edge
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h0;
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else if (ce)
        begin
            wr_pend <= addr_ok && hwrite;
            if (addr_ok)
            begin
                wr_addr <= {a_ofs[7:2], 2'b00};
            end
            if (addr_ok && !hwrite)
            begin
                hrdata <= next_rdata;
            end
        end
    end

    // ************************************************************
    // configuration
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl <= CTRL_RESET;
        end
        else if (ce && wr_pend && wr_addr == OFS_CTRL)
        begin
            ctrl <= hwdata[1:0];
        end
    end

    generate
        for (genvar p = 0; p < NUM_PROT; p++)
        begin : g_prot_thr
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    prot_thr[p] <= prot_limit(NOMINAL[p]);
                end
                else if (ce && wr_pend && wr_addr == OFS_PROT_THR + 8'(4 * p))
                begin
                    prot_thr[p] <= clip(hwdata[15:0], prot_limit(NOMINAL[p]));
                end
            end
        end
    endgenerate

    // profile change replaces every event setting at once
    generate
        for (genvar e = 0; e < NUM_EVENTS; e++)
        begin : g_ev_cfg
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    ev_cfg.threshold[e] <= 16'h0;
                    ev_cfg.action[e] <= ACT_NONE;
                end
                else if (ce)
                begin
                    if (wr_profile_default)
                    begin
                        ev_cfg.threshold[e] <= 16'h0;
                        ev_cfg.action[e] <= ACT_NONE;
                    end
                    else if (profile_load)
                    begin
                        ev_cfg.threshold[e] <= clip(profile_cfg.threshold[e], EV_NOMINAL[e]);
                        ev_cfg.action[e] <= profile_cfg.action[e];
                    end
                    else
                    begin
                        if (wr_pend && wr_addr == OFS_EVT_THR + 8'(4 * e))
                        begin
                            ev_cfg.threshold[e] <= clip(hwdata[15:0], EV_NOMINAL[e]);
                        end
                        if (wr_pend && wr_addr == OFS_EVT_ACTION)
                        begin
                            ev_cfg.action[e] <= hwdata[2*e +: 2];
                        end
                    end
                end
            end
        end
    endgenerate

    // ************************************************************
    // device protection alarms
    // ************************************************************
    logic [NUM_PROT-1:0][15:0] meas_vec;
    assign meas_vec = {meas.power, meas.current, meas.voltage};

    generate
        for (genvar p = 0; p < NUM_PROT; p++)
        begin : g_prot
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    prot_cond[p] <= 1'b0;
                    prot_pending[p] <= 1'b0;
                end
                else if (ce)
                begin
                    if (meas_valid)
                    begin
                        prot_cond[p] <= meas_vec[p] > prot_thr[p];
                    end
                    // ack only clears once the cause is gone; a raise wins over it
                    if (prot_cond[p])
                    begin
                        prot_pending[p] <= 1'b1;
                    end
                    else if (wr_ack && hwdata[p])
                    begin
                        prot_pending[p] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // ************************************************************
    // user events
    // ************************************************************
    logic [NUM_EVENTS-1:0][15:0] ev_meas;
    logic [NUM_EVENTS-1:0] ev_below;
    assign ev_meas = {meas.power, meas.current, meas.current, meas.voltage, meas.voltage};
    assign ev_below = 5'h05; // undervoltage and undercurrent trigger below threshold

    logic [NUM_EVENTS-1:0] ev_rise;
    generate
        for (genvar e = 0; e < NUM_EVENTS; e++)
        begin : g_event
            logic hit;
            // evaluated regardless of dc input state
            assign hit = ev_below[e] ? (ev_meas[e] < ev_cfg.threshold[e])
                : (ev_meas[e] > ev_cfg.threshold[e]);
            assign ev_rise[e] = meas_valid && hit && !ev_cond[e]
                && ev_cfg.action[e] != ACT_NONE;

            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    ev_cond[e] <= 1'b0;
                    ev_fired[e] <= 1'b0;
                    ev_alarm[e] <= 1'b0;
                end
                else if (ce)
                begin
                    if (meas_valid)
                    begin
                        ev_cond[e] <= hit && ev_cfg.action[e] != ACT_NONE;
                    end
                    if (ev_rise[e])
                    begin
                        ev_fired[e] <= 1'b1;
                        ev_alarm[e] <= ev_cfg.action[e] == ACT_ALARM;
                    end
                    else if (wr_ack && hwdata[ACK_EVENT_BIT])
                    begin
                        ev_fired[e] <= 1'b0;
                        ev_alarm[e] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // ************************************************************
    // indications and dc input control
    // ************************************************************
    logic [NUM_EVENTS-1:0] ev_warn;
    always_comb
    begin
        for (int e = 0; e < NUM_EVENTS; e++)
        begin
            ev_warn[e] = ev_fired[e] && ev_cfg.action[e] == ACT_WARNING;
        end
    end

    logic any_alarm;
    assign any_alarm = (|prot_pending) || (|ev_alarm);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            indication <= '0;
            dc_input_on <= 1'b0;
            overvoltage_alarm_pin <= 1'b0;
            set_value_accept <= 1'b0;
        end
        else if (ce)
        begin
            indication.status_msg <= |ev_fired;
            indication.warning_popup <= |ev_warn;
            indication.alarm_popup <= any_alarm;
            indication.sound <= any_alarm && ctrl[CTRL_SOUND_BIT];
            // alarms and remote off override the panel on request
            dc_input_on <= ctrl[CTRL_DC_ON_BIT] && !any_alarm
                && !remote_off;
            overvoltage_alarm_pin <= prot_pending[0];
            set_value_accept <= remote_active;
        end
    end

    // ************************************************************
    // interrupts
    // ************************************************************
    logic [IRQ_W-1:0] irq_set;
    assign irq_set = {ev_rise, prot_cond & ~prot_pending};

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_status <= '0;
            irq_enable <= '0;
            irq <= 1'b0;
        end
        else if (ce)
        begin
            irq_status <= irq_set | (irq_status & ~(wr_irq_clear ? hwdata[IRQ_W-1:0] : '0));
            if (wr_pend && wr_addr == OFS_IRQ_ENABLE)
            begin
                irq_enable <= hwdata[IRQ_W-1:0];
            end
            irq <= |(irq_status & irq_enable);
        end
    end

endmodule : protection_monitor

// file: design/monitor_pkg.sv
// shared constants, types and register map for the protection and event monitor
package monitor_pkg;

    // ************************************************************
    // measurement scale
    // ************************************************************
    localparam int MEAS_W = 16;
    localparam logic [15:0] VOLT_NOMINAL = 16'h4000;
    localparam logic [15:0] CURR_NOMINAL = 16'h4000;
    localparam logic [15:0] POWER_NOMINAL = 16'h4000;
    localparam int PROT_NUM = 11;
    localparam int PROT_DEN = 10;
    localparam int NUM_EVENTS = 5;
    localparam int NUM_PROT = 3;

    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ACK = 8'h04;
    localparam logic [7:0] OFS_ALARM = 8'h08;
    localparam logic [7:0] OFS_PROT_THR = 8'h0c;
    localparam logic [7:0] OFS_EVT_THR = 8'h18;
    localparam logic [7:0] OFS_EVT_ACTION = 8'h2c;
    localparam logic [7:0] OFS_EVT_STATUS = 8'h30;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h34;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h38;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h3c;
    localparam logic [7:0] OFS_PROFILE = 8'h40;
    localparam logic [7:0] OFS_STATE = 8'h44;

    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int CTRL_SOUND_BIT = 0;
    localparam int CTRL_DC_ON_BIT = 1;
    localparam int ACK_EVENT_BIT = 3;
    localparam int PROFILE_DEFAULT_BIT = 0;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam int IRQ_W = NUM_PROT + NUM_EVENTS;

    // event order: undervoltage, overvoltage, undercurrent, overcurrent, overpower
    localparam int EV_UNDERVOLTAGE = 0;
    localparam int EV_OVERVOLTAGE = 1;
    localparam int EV_UNDERCURRENT = 2;
    localparam int EV_OVERCURRENT = 3;
    localparam int EV_OVERPOWER = 4;

    typedef enum logic [1:0] {
        ACT_NONE,
        ACT_SIGNAL,
        ACT_WARNING,
        ACT_ALARM
    } action_e;

    typedef struct packed {
        logic [15:0] voltage;
        logic [15:0] current;
        logic [15:0] power;
    } meas_s;

    typedef struct packed {
        logic [NUM_EVENTS-1:0][15:0] threshold;
        logic [NUM_EVENTS-1:0][1:0] action;
    } event_cfg_s;

    typedef struct packed {
        logic status_msg;
        logic warning_popup;
        logic alarm_popup;
        logic sound;
    } indication_s;

endpackage : monitor_pkg

// file: verif/remote_ctrl.sv
// remote controller model driving the open-collector control pins of the analog port
module remote_ctrl
(
    input wire logic hclk,
    input wire logic remote_req,
    input wire logic off_req,
    output logic remote_enable_n,
    output logic input_off_request_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // pins
    // ************************************************************
    // open collector with pull-up: a released pin reads high, never left floating
    initial
    begin
        remote_enable_n = 1'b1;
        input_off_request_n = 1'b1;
    end
    always @(posedge hclk)
    begin
        remote_enable_n <= !remote_req;
        input_off_request_n <= !(remote_req && off_req);
    end
endmodule : remote_ctrl

// file: verif/monitor_chk.sv
// concurrent checks on the ports of the protection and event monitor
module monitor_chk
    import monitor_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire monitor_pkg::meas_s meas,
    input wire logic meas_valid,
    input wire logic remote_enable_n,
    input wire logic input_off_request_n,
    input wire logic dc_input_on,
    input wire logic overvoltage_alarm_pin,
    input wire logic set_value_accept,
    input wire monitor_pkg::indication_s indication
);
    timeunit 1ns;
    timeprecision 1ps;
    // equal to the highest programmable threshold, so a value above it trips whatever was written
    localparam logic [15:0] PROT_CEIL = 16'h4666;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // ************************************************************
    // sequences
    // ************************************************************
    sequence s_over;
        meas_valid && (meas.voltage > PROT_CEIL || meas.current > PROT_CEIL
            || meas.power > PROT_CEIL);
    endsequence
    sequence s_alarm_out;
        ##3 (!dc_input_on && indication.alarm_popup);
    endsequence
    // ************************************************************
    // assertions
    // ************************************************************
    AST_BUS_OKAY: assert property (hreadyout && !hresp)
        else $error("bus slave stalled or answered with an error");
    AST_PROT_RESPONSE: assert property (s_over |-> s_alarm_out)
        else $error("protection trip did not cut the input and show the alarm");
    AST_OVP_PIN: assert property (meas_valid && meas.voltage > PROT_CEIL
        |-> ##3 overvoltage_alarm_pin)
        else $error("overvoltage trip did not reach the alarm pin");
    AST_OVP_DC_OFF: assert property (overvoltage_alarm_pin |-> !dc_input_on)
        else $error("input on while overvoltage alarm pending");
    AST_POPUP_DC_OFF: assert property (indication.alarm_popup
        && $past(indication.alarm_popup) |-> !dc_input_on)
        else $error("input on during alarm pop-up");
    AST_SOUND_POPUP: assert property (indication.sound |-> indication.alarm_popup)
        else $error("sound without alarm");
    AST_WARN_STATUS: assert property (indication.warning_popup
        |-> indication.status_msg)
        else $error("warning pop-up without status message");
    AST_REMOTE_OFF: assert property (!$past(remote_enable_n, 3)
        && !$past(input_off_request_n, 3) |-> !dc_input_on)
        else $error("remote off request ignored");
    AST_ACCEPT_REMOTE: assert property (set_value_accept
        == !$past(remote_enable_n, 3))
        else $error("set value acceptance does not follow remote enable");
endmodule : monitor_chk

bind protection_monitor monitor_chk i_chk (.hclk(hclk), .hresetn(hresetn),
    .hreadyout(hreadyout), .hresp(hresp), .meas(meas), .meas_valid(meas_valid),
    .remote_enable_n(remote_enable_n), .input_off_request_n(input_off_request_n),
    .dc_input_on(dc_input_on), .overvoltage_alarm_pin(overvoltage_alarm_pin),
    .set_value_accept(set_value_accept), .indication(indication));

// file: verif/tb.sv
// self-checking bench for the protection and event monitor
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import monitor_pkg::*;
    typedef struct packed {
        logic [2:0] ev;
        logic [1:0] act;
        logic [47:0] m;
        logic [3:0] ind;
    } row_s;
    // none row first: it relies on indications still clear
    localparam row_s ROWS [7] = '{'{3'h0, 2'h0, 48'h1000_2000_2000, 4'h0},
        '{3'h0, 2'h1, 48'h1000_2000_2000, 4'h8}, '{3'h1, 2'h2, 48'h3000_2000_2000, 4'hc},
        '{3'h2, 2'h3, 48'h2000_1000_2000, 4'hb}, '{3'h3, 2'h1, 48'h2000_3000_2000, 4'h8},
        '{3'h4, 2'h2, 48'h2000_2000_3000, 4'hc}, '{3'h4, 2'h3, 48'h2000_2000_3000, 4'hb}};
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0, meas_valid = 1'b0, profile_load = 1'b0;
    logic remote_req = 1'b0, off_req = 1'b0;
    logic hreadyout, hresp, dc_input_on, overvoltage_alarm_pin, set_value_accept, irq;
    logic remote_enable_n, input_off_request_n;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, e;
    logic [47:0] m;
    meas_s meas = '0;
    event_cfg_s profile_cfg = '0;
    indication_s indication;
    int errors = 0, check_count = 0;
    initial
    begin
        forever #50 hclk = ~hclk;
    end
    protection_monitor i_dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .meas(meas), .meas_valid(meas_valid), .profile_load(profile_load),
        .profile_cfg(profile_cfg), .remote_enable_n(remote_enable_n),
        .input_off_request_n(input_off_request_n), .dc_input_on(dc_input_on),
        .overvoltage_alarm_pin(overvoltage_alarm_pin), .set_value_accept(set_value_accept),
        .indication(indication), .irq(irq));
    remote_ctrl i_remote (.hclk(hclk), .remote_req(remote_req), .off_req(off_req),
        .remote_enable_n(remote_enable_n), .input_off_request_n(input_off_request_n));
    // ************************************************************
    // tasks
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check
    task automatic wait_ready();
        @(posedge hclk);
        while (hreadyout !== 1'b1)
        begin
            @(posedge hclk);
        end
    endtask : wait_ready
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
    endtask : bus
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rdchk
    task automatic upd(input logic [47:0] v);
        meas <= v;
        meas_valid <= 1'b1;
        @(posedge hclk);
        meas_valid <= 1'b0;
        repeat (4) @(posedge hclk);
    endtask : upd
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    initial
    begin
        repeat (20000) @(posedge hclk);
        errors++;
        finish_test();
    end
    // ************************************************************
    // main sequence
    // ************************************************************
    initial
    begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check(dc_input_on, 1'b0);
        for (int k = 0; k < 3; k++)
            rdchk(OFS_PROT_THR + 8'(4 * k), 32'h4666);
        rdchk(OFS_EVT_ACTION, 32'h0);
        rdchk(8'h48, 32'h0);
        bus(1'b1, OFS_PROT_THR, 32'hffff);
        rdchk(OFS_PROT_THR, 32'h4666);
        bus(1'b1, OFS_EVT_THR, 32'hffff);
        rdchk(OFS_EVT_THR, 32'h4000);
        for (int k = 0; k < 5; k++)
            bus(1'b1, OFS_EVT_THR + 8'(4 * k), 32'h2000);
        bus(1'b1, OFS_CTRL, 32'h3);
        bus(1'b1, OFS_IRQ_ENABLE, 32'hff);
        upd(48'h2000_2000_2000);
        check(dc_input_on, 1'b1);
        $display("test reset and limits done");
        foreach (ROWS[i])
        begin
            bus(1'b1, OFS_EVT_ACTION, 32'(ROWS[i].act) << (2 * ROWS[i].ev));
            upd(ROWS[i].m);
            check(indication, ROWS[i].ind);
            check(dc_input_on, ROWS[i].act != ACT_ALARM);
            check(irq, ROWS[i].act != ACT_NONE);
            e = (32'(ROWS[i].act != ACT_NONE) << ROWS[i].ev);
            e = e | (32'(ROWS[i].act == ACT_ALARM) << (5 + ROWS[i].ev));
            rdchk(OFS_EVT_STATUS, e);
            bus(1'b1, OFS_ACK, 32'h8);
            bus(1'b1, OFS_EVT_ACTION, 32'h0);
            bus(1'b1, OFS_IRQ_CLEAR, 32'hff);
            upd(48'h2000_2000_2000);
        end
        $display("test event actions done");
        for (int k = 0; k < 3; k++)
        begin
            m = {3{16'h2000}};
            m[47 - 16 * k -: 16] = 16'h5000;
            bus(1'b1, OFS_CTRL, (k == 1) ? 32'h2 : 32'h3);
            upd(m);
            check(dc_input_on, 1'b0);
            check(indication.alarm_popup, 1'b1);
            check(indication.sound, k != 1);
            check(overvoltage_alarm_pin, k == 0);
            rdchk(OFS_IRQ_STATUS, 32'h1 << k);
            bus(1'b1, OFS_IRQ_ENABLE, 32'h0);
            repeat (2) @(posedge hclk);
            check(irq, 1'b0);
            bus(1'b1, OFS_IRQ_ENABLE, 32'hff);
            repeat (2) @(posedge hclk);
            check(irq, 1'b1);
            bus(1'b1, OFS_IRQ_CLEAR, 32'hff);
            repeat (2) @(posedge hclk);
            check(irq, 1'b0);
            rdchk(OFS_ALARM, 32'h9 << k);
            bus(1'b1, OFS_ACK, 32'h1 << k);
            rdchk(OFS_ALARM, 32'h9 << k);
            upd({3{16'h2000}});
            rdchk(OFS_ALARM, 32'h1 << k);
            check(dc_input_on, 1'b0);
            bus(1'b1, OFS_ACK, 32'h1 << k);
            rdchk(OFS_ALARM, 32'h0);
            check(dc_input_on, 1'b1);
            check(overvoltage_alarm_pin, 1'b0);
        end
        $display("test protection alarms done");
        profile_cfg <= {{5{16'h1234}}, {5{2'h3}}};
        profile_load <= 1'b1;
        @(posedge hclk);
        profile_load <= 1'b0;
        rdchk(OFS_EVT_ACTION, 32'h3ff);
        rdchk(OFS_EVT_THR, 32'h1234);
        bus(1'b1, OFS_PROFILE, 32'h1);
        rdchk(OFS_EVT_ACTION, 32'h0);
        rdchk(OFS_EVT_THR + 8'h4, 32'h0);
        bus(1'b1, OFS_CTRL, 32'h1);
        bus(1'b1, OFS_EVT_ACTION, 32'h4);
        upd(48'h2000_2000_2000);
        check(indication.status_msg, 1'b1);
        bus(1'b1, OFS_ACK, 32'h8);
        bus(1'b1, OFS_EVT_ACTION, 32'h0);
        bus(1'b1, OFS_CTRL, 32'h3);
        $display("test profile and input-off events done");
        remote_req <= 1'b1;
        repeat (5) @(posedge hclk);
        check(set_value_accept, 1'b1);
        check(dc_input_on, 1'b1);
        off_req <= 1'b1;
        repeat (5) @(posedge hclk);
        check(dc_input_on, 1'b0);
        off_req <= 1'b0;
        repeat (5) @(posedge hclk);
        check(dc_input_on, 1'b1);
        remote_req <= 1'b0;
        repeat (5) @(posedge hclk);
        check(set_value_accept, 1'b0);
        $display("test remote pins done");
        finish_test();
    end
endmodule : tb
